/* rtl/sbmd_top.sv */
// Purpose: Decodes the system address space into board RAM and ROM,
//          picks wait states, sizes the module and paces refresh.
// Assumes: i_sys_addr and i_sys_req come from logic on i_core_clk;
//          sense lines and setup mode are board pins.
// Notes:   Decode results appear one clock after the request.
//          RAM and ROM selects never overlap; the video, expansion ROM
//          and channel windows are never claimed by this block.
// Behaviour
// - Board RAM begins at address zero.
// - 000000..09FFFF decodes as first 640KB RAM.
// - Expansion ROM window 0C0000..0DFFFF left alone.
// - Board ROM at 0E0000 and FE0000 aliases.
// - Remaining 384KB RAM at 100000..15FFFF.
// - 160000..FDFFFF stays unclaimed for channel memory.
// - Setup mode lets option register disable RAM.
// - No ROM parity; RAM has byte parity.
// - ROM is 16-bit wide, 64K words.
// - First board type: one wait state.
// - 120 ns one wait; 85 ns none.
// - Refresh requested about every 15 us.
// - Sense lines decode three supported module codes.
// - Refresh requests at arbitration level minus two.
`include "sbmd_defs.svh"

module sbmd_top (
  // Clock and reset.
  input  wire logic                    i_core_clk,
  input  wire logic                    i_rst,
  // Avalon-MM register slave.
  input  wire logic [3:0]              i_avs_address,
  input  wire logic                    i_avs_read,
  input  wire logic                    i_avs_write,
  input  wire logic [31:0]             i_avs_writedata,
  input  wire logic [3:0]              i_avs_byteenable,
  output logic [31:0]                  o_avs_readdata,
  output logic                         o_avs_waitrequest,
  // System bus decode.
  input  wire logic                    i_sys_req,
  input  wire logic [23:0]             i_sys_addr,
  output sbmd_pkg::sbmd_dec_t          o_dec,
  // Board pins.
  input  wire logic [3:0]              i_sense,
  input  wire logic                    i_setup_mode,
  // Refresh request towards the arbiter.
  input  wire logic                    i_refresh_gnt,
  output logic                         o_refresh_req,
  output logic [4:0]                   o_refresh_lvl
);
  import sbmd_pkg::*;

  localparam logic [7:0] REFRESH_LAST = 8'(`SBMD_REFRESH_CYC - 1);

  logic [3:0]  sense_sync;
  logic        setup_meta_reg;
  logic        setup_sync_reg;
  logic        mem_en_reg;
  logic        type1_reg;
  logic        ref_en_reg;
  logic [7:0]  ref_cnt_reg;
  logic [15:0] ref_total_reg;
  logic        ref_tick;
  sbmd_mod_t   mod_kind;
  logic        ram_present;
  logic        wait_one;
  logic        in_ram_lo;
  logic        in_ram_hi;
  logic        in_rom;
  sbmd_dec_t   dec_next;
  logic        bus_req;
  logic        bus_take;
  logic        wr_low;
  logic [31:0] rd_next;

  // The setup pin passes two flops before any logic looks at it. It
  // resets low, so no option write can slip through while it settles.
  always_ff @(posedge i_core_clk) begin
    if (i_rst) begin
      setup_meta_reg <= 1'h0;
      setup_sync_reg <= 1'h0;
    end else begin
      setup_meta_reg <= i_setup_mode;
      setup_sync_reg <= setup_meta_reg;
    end
  end

  // Each sense line has a two-flop synchroniser of its own. The flops
  // reset to the pulled-up level, so until real samples arrive the
  // decode sees an empty connector and maps no RAM.
  for (genvar g_line = 0; g_line < 4; g_line++) begin : g_sense_sync
    logic line_meta_reg;
    logic line_sync_reg;

    always_ff @(posedge i_core_clk) begin
      if (i_rst) begin
        line_meta_reg <= 1'h1;
        line_sync_reg <= 1'h1;
      end else begin
        line_meta_reg <= i_sense[g_line];
        line_sync_reg <= line_meta_reg;
      end
    end

    // Only the second flop leaves the loop.
    assign sense_sync[g_line] = line_sync_reg;
  end

  // An open line is pulled high, a grounded one reads low, so the codes
  // below are the inverse of the grounded pattern.
  always_comb begin
    case (sense_sync)
      `SBMD_SENSE_1M_120: mod_kind = SBMD_MOD_1M_120;
      `SBMD_SENSE_1M_85:  mod_kind = SBMD_MOD_1M_85;
      `SBMD_SENSE_2M_85:  mod_kind = SBMD_MOD_2M_85;
      default:            mod_kind = SBMD_MOD_NONE;
    endcase
  end

  // The first board type carries fixed 512KB packages with no usable
  // speed code, so it always maps RAM and always waits one state.
  always_comb begin
    if (type1_reg) begin
      ram_present = 1'h1;
      wait_one    = 1'h1;
    end else begin
      ram_present = (mod_kind != SBMD_MOD_NONE);
      wait_one    = (mod_kind == SBMD_MOD_1M_120);
    end
  end

  // Address windows. Video RAM and expansion ROM windows have no term
  // here at all, so nothing on the board can answer them.
  // Both ROM aliases compare the top seven address bits, 128KB apiece.
  assign in_ram_lo = (i_sys_addr <= `SBMD_RAM_LO_LAST);
  assign in_ram_hi = (i_sys_addr >= `SBMD_RAM_HI_BASE) &&
                     (i_sys_addr <= `SBMD_RAM_HI_LAST);
  assign in_rom    = (i_sys_addr[23:17] == `SBMD_ROM_TAG_LOW) ||
                     (i_sys_addr[23:17] == `SBMD_ROM_TAG_HIGH);

  // Build the decode result for the current request.
  // Fields that do not belong to the selected target stay zero, so a
  // consumer can compare whole words without masking.
  always_comb begin
    dec_next             = '0;
    dec_next.ram_sel     = i_sys_req && mem_en_reg && ram_present &&
                           (in_ram_lo || in_ram_hi);
    dec_next.rom_sel     = i_sys_req && in_rom;
    dec_next.claim       = dec_next.ram_sel || dec_next.rom_sel;
    dec_next.parity_en   = dec_next.ram_sel;
    dec_next.wait_st     = dec_next.ram_sel && wait_one;
    dec_next.rom_hi_byte = dec_next.rom_sel && i_sys_addr[0];
    if (dec_next.rom_sel) begin
      dec_next.rom_word = i_sys_addr[16:1];
    end
    // The upper 384KB folds onto module space just above the first 640KB.
    if (dec_next.ram_sel && in_ram_hi) begin
      dec_next.ram_off = i_sys_addr[19:0] + `SBMD_RAM_HI_REMAP;
    end else if (dec_next.ram_sel) begin
      dec_next.ram_off = i_sys_addr[19:0];
    end
  end

  // Decode output is registered so every output leaves a flop.
  // The price is one clock of decode latency on every access.
  always_ff @(posedge i_core_clk) begin
    if (i_rst) begin
      o_dec <= '0;
    end else begin
      o_dec <= dec_next;
    end
  end

  // Refresh interval counter; a tick every interval while enabled.
  // The count is fixed by the core clock period in the header, so a
  // different clock rate needs the header changed to keep the interval.
  assign ref_tick = ref_en_reg && (ref_cnt_reg == REFRESH_LAST);

  always_ff @(posedge i_core_clk) begin
    if (i_rst) begin
      ref_cnt_reg <= 8'h00;
    end else if (!ref_en_reg || ref_tick) begin
      ref_cnt_reg <= 8'h00;
    end else begin
      ref_cnt_reg <= ref_cnt_reg + 8'h01;
    end
  end

  // Request holds until granted. A new tick in the grant cycle wins,
  // so a due refresh is never dropped; back-to-back ticks merge.
  always_ff @(posedge i_core_clk) begin
    if (i_rst) begin
      o_refresh_req <= 1'h0;
    end else if (ref_tick) begin
      o_refresh_req <= 1'h1;
    end else if (i_refresh_gnt) begin
      o_refresh_req <= 1'h0;
    end
  end

  // Refresh always arbitrates above the interrupt and channel levels.
  // The level is minus two in a five-bit two's complement code.
  always_ff @(posedge i_core_clk) begin
    if (i_rst) begin
      o_refresh_lvl <= `SBMD_REFRESH_LVL;
    end else begin
      o_refresh_lvl <= `SBMD_REFRESH_LVL;
    end
  end

  // Count refreshes actually granted, for software health checks.
  always_ff @(posedge i_core_clk) begin
    if (i_rst) begin
      ref_total_reg <= 16'h0000;
    end else if (o_refresh_req && i_refresh_gnt) begin
      ref_total_reg <= ref_total_reg + 16'h0001;
    end
  end

  // Bus handshake: waitrequest drops for one cycle after a request is
  // seen; the write lands at the edge that ends it, the read data at the edge that starts it.
  // Registering waitrequest costs one wait state per access but keeps
  // the slave's outputs free of combinational paths from the master.
  assign bus_req  = i_avs_read || i_avs_write;
  assign bus_take = bus_req && !o_avs_waitrequest;
  assign wr_low   = bus_take && i_avs_write && i_avs_byteenable[0];

  always_ff @(posedge i_core_clk) begin
    if (i_rst) begin
      o_avs_waitrequest <= 1'h1;
    end else if (bus_req && o_avs_waitrequest) begin
      o_avs_waitrequest <= 1'h0;
    end else begin
      o_avs_waitrequest <= 1'h1;
    end
  end

  // Option register: board memory enable can change only in setup mode;
  // outside it the write completes but is dropped.
  always_ff @(posedge i_core_clk) begin
    if (i_rst) begin
      mem_en_reg <= `SBMD_OPT3_RST;
    end else if (wr_low && setup_sync_reg &&
                 (i_avs_address == `SBMD_OFS_OPT3)) begin
      mem_en_reg <= i_avs_writedata[`SBMD_OPT3_MEM_EN];
    end
  end

  // Control register, board type bit. Software sets it on a first-type
  // board, whose fixed packages drive no sense lines worth reading.
  always_ff @(posedge i_core_clk) begin
    if (i_rst) begin
      type1_reg <= `SBMD_TYPE1_RST;
    end else if (wr_low && (i_avs_address == `SBMD_OFS_CTRL)) begin
      type1_reg <= i_avs_writedata[`SBMD_CTRL_TYPE1];
    end
  end

  // Control register, refresh enable bit. Clearing it stops the interval
  // counter; DRAM contents are lost if it stays clear for long.
  always_ff @(posedge i_core_clk) begin
    if (i_rst) begin
      ref_en_reg <= `SBMD_REF_EN_RST;
    end else if (wr_low && (i_avs_address == `SBMD_OFS_CTRL)) begin
      ref_en_reg <= i_avs_writedata[`SBMD_CTRL_REF_EN];
    end
  end

  // Read multiplexer; unmapped offsets read as zero.
  // Status shows synchronised pins, so a pin change appears two clocks late.
  always_comb begin
    rd_next = 32'h00000000;
    case (i_avs_address)
      `SBMD_OFS_OPT3: begin
        rd_next[`SBMD_OPT3_MEM_EN] = mem_en_reg;
      end
      `SBMD_OFS_CTRL: begin
        rd_next[`SBMD_CTRL_TYPE1]  = type1_reg;
        rd_next[`SBMD_CTRL_REF_EN] = ref_en_reg;
      end
      `SBMD_OFS_STATUS: begin
        rd_next[3:0] = sense_sync;
        rd_next[5:4] = mod_kind;
        rd_next[6]   = wait_one;
        rd_next[7]   = ram_present;
        rd_next[8]   = setup_sync_reg;
        rd_next[9]   = o_refresh_req;
      end
      `SBMD_OFS_REFCNT: begin
        rd_next[15:0] = ref_total_reg;
      end
      default: begin
        rd_next = 32'h00000000;
      end
    endcase
  end

  // Read data is loaded with the waitrequest drop and held after.
  always_ff @(posedge i_core_clk) begin
    if (i_rst) begin
      o_avs_readdata <= 32'h00000000;
    end else if (i_avs_read && o_avs_waitrequest) begin
      o_avs_readdata <= rd_next;
    end
  end

endmodule : sbmd_top

/* inc/sbmd_defs.svh */
// Purpose: Constants of the system-board memory decode block.
// Assumes: 24-bit system address, 10 MHz core clock.
// Notes:   Register offsets are byte addresses on the Avalon-MM slave.
`ifndef SBMD_DEFS_SVH
`define SBMD_DEFS_SVH

// Address map limits.
`define SBMD_RAM_LO_BASE   24'h000000
`define SBMD_RAM_LO_LAST   24'h09ffff
`define SBMD_RAM_HI_BASE   24'h100000
`define SBMD_RAM_HI_LAST   24'h15ffff
`define SBMD_RAM_HI_REMAP  20'ha0000
`define SBMD_ROM_TAG_LOW   7'h07
`define SBMD_ROM_TAG_HIGH  7'h7f

// Sense codes as read through pull-ups: grounded line reads 0.
`define SBMD_SENSE_1M_120  4'he
`define SBMD_SENSE_1M_85   4'h6
`define SBMD_SENSE_2M_85   4'h5

// Refresh timing.
`define SBMD_CLK_PERIOD_NS 100
`define SBMD_REFRESH_NS    15000
`define SBMD_REFRESH_CYC   (`SBMD_REFRESH_NS / `SBMD_CLK_PERIOD_NS)
`define SBMD_REFRESH_LVL   5'h1e

// Register offsets.
`define SBMD_OFS_OPT3      4'h0
`define SBMD_OFS_CTRL      4'h4
`define SBMD_OFS_STATUS    4'h8
`define SBMD_OFS_REFCNT    4'hc

// Field positions and reset values.
`define SBMD_OPT3_MEM_EN   0
`define SBMD_CTRL_TYPE1    0
`define SBMD_CTRL_REF_EN   1
`define SBMD_OPT3_RST      1'h1
`define SBMD_TYPE1_RST     1'h0
`define SBMD_REF_EN_RST    1'h1

`endif

/* inc/sbmd_pkg.sv */
// Purpose: Types of the system-board memory decode block.
// Assumes: Included after sbmd_defs.svh where constants are needed.
// Notes:   The decode result travels as one packed struct.
package sbmd_pkg;

  // Installed module kind as decoded from the sense lines.
  typedef enum logic [1:0] {
    SBMD_MOD_NONE   = 2'h0,
    SBMD_MOD_1M_120 = 2'h1,
    SBMD_MOD_1M_85  = 2'h2,
    SBMD_MOD_2M_85  = 2'h3
  } sbmd_mod_t;

  // Result of one address decode.
  typedef struct packed {
    logic        claim;
    logic        ram_sel;
    logic        rom_sel;
    logic        parity_en;
    logic        wait_st;
    logic        rom_hi_byte;
    logic [19:0] ram_off;
    logic [15:0] rom_word;
  } sbmd_dec_t;

endpackage : sbmd_pkg

/* verif/sbmd_top_props.sv */
// Purpose: Port-level checks of the memory decode block.
// Assumes: Bound to sbmd_top; decode answers one clock after a request.
// Notes:   Only address map, parity, wait state and refresh relations are watched.
module sbmd_top_props
  import sbmd_pkg::*;
(
  // Clock and reset.
  input wire logic        i_core_clk,
  input wire logic        i_rst,
  // Decode side.
  input wire logic        i_sys_req,
  input wire logic [23:0] i_sys_addr,
  input wire sbmd_dec_t   o_dec,
  // Refresh side.
  input wire logic        i_refresh_gnt,
  input wire logic        o_refresh_req,
  input wire logic [4:0]  o_refresh_lvl
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [23:0] a;

  // Short alias keeps the properties readable.
  assign a = i_sys_addr;

  default clocking cb @(posedge i_core_clk); endclocking
  default disable iff (i_rst);

  // Address windows and their answers one clock later.
  a_video_hole: assert property (i_sys_req && a inside {[24'h0a0000:24'h0dffff]}
    |=> !o_dec.claim) else $error("window below ROM claimed");
  a_chan_hole: assert property (i_sys_req && a inside {[24'h160000:24'hfdffff]}
    |=> !o_dec.claim) else $error("channel memory range claimed");
  a_rom_alias: assert property (i_sys_req && (a[23:17] == 7'h07 || a[23:17] == 7'h7f)
    |=> o_dec.rom_sel && !o_dec.parity_en && o_dec.rom_word == $past(a[16:1]))
    else $error("ROM alias decoded wrongly");
  a_low_ram: assert property (i_sys_req && a <= 24'h09ffff ##1 o_dec.ram_sel
    |-> o_dec.ram_off == $past(a[19:0])) else $error("low RAM offset wrong");
  a_high_ram: assert property (i_sys_req && a inside {[24'h100000:24'h15ffff]}
    ##1 o_dec.ram_sel |-> o_dec.ram_off == $past(a[19:0]) + 20'ha0000)
    else $error("high RAM offset wrong");
  // Parity belongs to RAM only; a wait state never goes with ROM.
  a_ram_parity: assert property (o_dec.ram_sel |-> o_dec.parity_en && o_dec.claim
    && !o_dec.rom_sel) else $error("RAM select without parity");
  a_wait_ram: assert property (o_dec.wait_st |-> o_dec.ram_sel)
    else $error("wait state outside RAM");
  // A refresh request stands until granted, at the top level.
  a_refresh_hold: assert property (o_refresh_req && !i_refresh_gnt |=> o_refresh_req)
    else $error("refresh request dropped ungranted");
  a_refresh_level: assert property (o_refresh_lvl == 5'h1e)
    else $error("refresh level wrong");

  c_rom: cover property (o_dec.rom_sel);
  c_slow_ram: cover property (o_dec.ram_sel && o_dec.wait_st);
  c_refresh: cover property (o_refresh_req && i_refresh_gnt);
endmodule : sbmd_top_props

/* verif/sbmd_dram_model.sv */
// Purpose: Sense pins of the fitted memory module package.
// Assumes: Each pin has a board pull-up.
// Notes:   An off-list code stands for an unsupported package.
module sbmd_dram_model
  import sbmd_pkg::*;
(
  // Fitted package and off-list choice.
  input  wire sbmd_mod_t i_kind,
  input  wire logic      i_bad,
  // Sense pins as the board reads them.
  output logic [3:0]     o_sense
);
  timeunit 1ns;
  timeprecision 1ns;

  // Grounded reads 0; an open pin floats up to 1.
  always_comb begin
    case (i_kind)
      SBMD_MOD_1M_120: o_sense = 4'he;
      SBMD_MOD_1M_85:  o_sense = 4'h6;
      SBMD_MOD_2M_85:  o_sense = 4'h5;
      default:         o_sense = i_bad ? 4'ha : 4'hf;
    endcase
  end
endmodule : sbmd_dram_model

/* verif/system_board_memory_decode_bench.sv */
// Purpose: Self-checking bench of the memory decode block.
// Assumes: 10 MHz clock; sense pins come from the module model.
// Notes:   Expected decodes are built by exp_of from the address map.
module system_board_memory_decode_bench
  import sbmd_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  logic        clk, rst, rd, wr, wq, req, gnt, rr, setup, bad, ram_ok, slow;
  logic [3:0]  adr, be, sense;
  logic [31:0] wdat, rdat;
  logic [23:0] addr;
  logic [4:0]  lvl;
  sbmd_dec_t   dec;
  sbmd_mod_t   kind;
  int          err_count, samples_checked, seed, n, k, gap;
  logic [6:0]  blk [16] = '{7'h00, 7'h02, 7'h04, 7'h05, 7'h06, 7'h07, 7'h08, 7'h0a,
                            7'h0b, 7'h40, 7'h7e, 7'h7f, 7'h03, 7'h01, 7'h09, 7'h07};
  logic [23:0] corner [8] = '{24'h09ffff, 24'h0a0000, 24'h0dffff, 24'h0e0001,
                              24'h15ffff, 24'h160000, 24'hfdffff, 24'hfe0000};

  sbmd_top i_dut (.i_core_clk(clk), .i_rst(rst), .i_avs_address(adr), .i_avs_read(rd),
    .i_avs_write(wr), .i_avs_writedata(wdat), .i_avs_byteenable(be),
    .o_avs_readdata(rdat), .o_avs_waitrequest(wq), .i_sys_req(req), .i_sys_addr(addr),
    .o_dec(dec), .i_sense(sense), .i_setup_mode(setup), .i_refresh_gnt(gnt),
    .o_refresh_req(rr), .o_refresh_lvl(lvl));
  sbmd_dram_model i_mod (.i_kind(kind), .i_bad(bad), .o_sense(sense));

  // Free-running core clock.
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end

  // Expected decode of one address for the present module setting.
  function automatic sbmd_dec_t exp_of(input logic [23:0] x);
    sbmd_dec_t e;
    e = '0;
    if (ram_ok && (x <= 24'h09ffff || x inside {[24'h100000:24'h15ffff]})) begin
      e.ram_sel   = 1'b1;
      e.parity_en = 1'b1;
      e.wait_st   = slow;
      e.ram_off   = x[20] ? x[19:0] + 20'ha0000 : x[19:0];
    end
    if (x[23:17] == 7'h07 || x[23:17] == 7'h7f) begin
      e.rom_sel     = 1'b1;
      e.rom_hi_byte = x[0];
      e.rom_word    = x[16:1];
    end
    e.claim = e.ram_sel | e.rom_sel;
    return e;
  endfunction : exp_of

  task automatic give_verdict();
    $display("checked %0d, wrong %0d", samples_checked, err_count);
    if (err_count == 0 && samples_checked > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask : give_verdict

  task automatic chk(input logic [45:0] got, input logic [45:0] exp);
    samples_checked++;
    if (got !== exp) begin
      err_count++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  // One Avalon access; the request stands until waitrequest is seen low.
  task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d,
                     input logic [3:0] b);
    @(posedge clk);
    rd   <= !w;
    wr   <= w;
    adr  <= a;
    wdat <= d;
    be   <= b;
    k = 0;
    do begin
      @(posedge clk);
      k++;
    end while (wq !== 1'b0 && k < 20);
    rd <= 1'b0;
    wr <= 1'b0;
    if (wq !== 1'b0) begin
      err_count++;
      give_verdict();
    end
  endtask : bus

  task automatic rd_chk(input logic [3:0] a, input logic [31:0] e);
    bus(1'b0, a, 32'h0, 4'hf);
    chk({14'h0, rdat}, {14'h0, e});
  endtask : rd_chk

  // Decode answers one clock after the sampling edge.
  task automatic dec_chk(input logic [23:0] x);
    @(posedge clk);
    req  <= 1'b1;
    addr <= x;
    repeat (2) @(posedge clk);
    #1 chk(46'(dec), 46'(exp_of(x)));
  endtask : dec_chk

  // Waits for a refresh request, then grants it for one clock.
  task automatic grant(output int c);
    c = 0;
    do begin
      @(posedge clk);
      c++;
    end while (rr !== 1'b1 && c < 200);
    if (rr !== 1'b1) begin
      err_count++;
      give_verdict();
    end
    gnt <= 1'b1;
    @(posedge clk);
    gnt <= 1'b0;
  endtask : grant

  task automatic run_pass(input logic st);
    repeat (4) @(posedge clk);
    if (st) rd_chk(4'h8, {22'h0, 1'b0, setup, ram_ok, slow, kind, sense});
    foreach (corner[i]) dec_chk(corner[i]);
    for (int j = 0; j < 16; j++) begin
      n = $random(seed);
      dec_chk({blk[n[3:0]], n[20:4]});
    end
  endtask : run_pass

  // Main sequence: registers, refresh pacing, every module kind, board type, setup.
  initial begin
    seed = 16;
    {rd, wr, req, gnt, setup, bad, ram_ok, slow} = 8'h00;
    rst  = 1'b1;
    adr  = 4'h0;
    be   = 4'hf;
    wdat = 32'h0;
    addr = 24'h0;
    kind = SBMD_MOD_NONE;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    rd_chk(4'h0, 32'h1);
    rd_chk(4'h4, 32'h2);
    rd_chk(4'h1, 32'h0);
    grant(gap);
    grant(gap);
    chk(46'(gap), 46'd149);
    chk(46'(lvl), 46'h1e);
    bus(1'b1, 4'h4, 32'h0, 4'hf);
    bus(1'b1, 4'h4, 32'h3, 4'he);
    rd_chk(4'h4, 32'h0);
    rd_chk(4'hc, 32'h2);
    for (int i = 0; i < 5; i++) begin
      kind   <= sbmd_mod_t'(i[1:0]);
      bad    <= (i == 4);
      ram_ok = (i[1:0] != 2'h0);
      slow   = (i[1:0] == 2'h1);
      run_pass(1'b1);
    end
    bus(1'b1, 4'h4, 32'h1, 4'hf);
    {ram_ok, slow} = 2'b11;
    run_pass(1'b0);
    bus(1'b1, 4'h0, 32'h0, 4'hf);
    rd_chk(4'h0, 32'h1);
    setup <= 1'b1;
    repeat (4) @(posedge clk);
    bus(1'b1, 4'h0, 32'h0, 4'hf);
    rd_chk(4'h0, 32'h0);
    ram_ok = 1'b0;
    run_pass(1'b0);
    give_verdict();
  end
endmodule : system_board_memory_decode_bench

bind sbmd_top sbmd_top_props i_props (.*);
